//--- hdl/host_port_cfg.svh
// constants for the shared host data-pin port
`ifndef HOST_PORT_CFG_SVH
`define HOST_PORT_CFG_SVH

// serial frame counts
`define CTRL_LAST 5'h0f
`define DATA_FIRST 5'h10
`define BYTE_END 5'h17
// control word positions; read/write and burst fixed whatever the bit order, address low bit only with the strap low
`define RW_POS 0
`define BURST_POS 15
`define ADDR_LO_POS 1
// dual-function data pin positions
`define POL_PIN 7
`define PHA_PIN 6
`define SWAP_PIN 5
`define MOSI_PIN 1
// strap reset level
`define STRAP_RESET 1'b0
// timing
`define CLK_PERIOD_NS 50
`define READ_GAP_NS 400
`define READ_GAP_CYC ((`READ_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

//--- hdl/host_port_pins.sv
// host data pins: parallel bus or strapped serial port
`include "host_port_cfg.svh"

// Behaviour
// [RL1] Write data is taken from the data pins on writes and the addressed register is driven on reads.
// [RL2] No data pin is driven while chip select is high.
// [RL3] In serial mode data pin 7 is a strap setting clock polarity, low by default.
// [RL4] In serial mode data pin 6 is a strap setting clock phase, low by default.
// [RL5] A high bit-order strap reverses the order of both address and data bits.
// [RL6] The read/write flag and the burst bit keep fixed places in the control word.
// [RL7] Strap low shifts least significant bit first, strap high most significant first.
// [RL8] In serial mode the host clocks the link on data pin 2, an input of the device.
// [RL9] The host picks parallel mode with the mode select low and serial mode with it high.
// [RL10] In serial mode the device sends on data pin 0 and receives on data pin 1.
// [RL11] Strobes count only while chip select is low.
// [RL12] In parallel mode the host gives a 13-bit register address.
// [RL13] The host keeps the straps steady while a transfer is in progress.
// [RL14] Straps are sampled only in serial mode and ignored in parallel mode.
module host_port_pins
	import host_port_pkg::*;
(
	// system
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic clk_en,
	// serial clock, taken from data pin 2
	input wire logic serial_clk,
	// host pins
	input wire logic serial_mode_sel,
	input wire logic chip_select_n,
	input wire logic read_n,
	input wire logic write_n,
	input wire reg_addr_t addr_pin,
	input wire reg_data_t data_in,
	output reg_data_t data_out,
	output reg_data_t data_oe,
	output logic serial_data_out,
	// register side
	output reg_addr_t reg_addr,
	output reg_data_t reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire reg_data_t reg_rdata
);

	// ==========================================
	// pin synchronisers
	logic [24:0] pin_s1;
	logic [24:0] pin_s2;
	logic mode_s;
	logic cs_n_s;
	logic rd_n_s;
	logic wr_n_s;
	reg_addr_t addr_s;
	reg_data_t din_s;
	logic rd_n_d;
	logic wr_n_d;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			pin_s1 <= '1;
			pin_s2 <= '1;
			rd_n_d <= 1'b1;
			wr_n_d <= 1'b1;
		end else if (clk_en) begin
			pin_s1 <= {serial_mode_sel, chip_select_n, read_n, write_n, addr_pin, data_in};
			pin_s2 <= pin_s1;
			rd_n_d <= rd_n_s;
			wr_n_d <= wr_n_s;
		end
	end

	assign mode_s = pin_s2[24];
	assign cs_n_s = pin_s2[23];
	assign rd_n_s = pin_s2[22];
	assign wr_n_s = pin_s2[21];
	assign addr_s = pin_s2[20:8];
	assign din_s = pin_s2[7:0];

	// ==========================================
	// straps
	logic pol;
	logic pha;
	logic swap;

	// captured only between serial frames so the link clock never glitches mid-frame
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			pol <= `STRAP_RESET;
			pha <= `STRAP_RESET;
			swap <= `STRAP_RESET;
		end else if (clk_en && mode_s && cs_n_s) begin // RL14
			pol <= din_s[`POL_PIN]; // RL3
			pha <= din_s[`PHA_PIN]; // RL4
			swap <= din_s[`SWAP_PIN]; // RL5
		end
	end

	// ==========================================
	// serial link domain
	logic lclk;
	logic frame_rst_n;
	logic mosi;
	logic [4:0] cnt;
	link_phase_e phase;
	logic [15:0] ctrl;
	logic [15:0] next_ctrl;
	reg_data_t rx_byte;
	reg_data_t next_byte;
	reg_addr_t lk_addr;
	logic lk_rw;
	logic lk_burst;
	logic xfer_tgl;
	reg_addr_t req_addr;
	reg_data_t req_wdata;
	logic req_rw;

	// sampling edge is rising when polarity equals phase, else falling
	assign lclk = serial_clk ^ (pol ^ pha); // RL8
	assign frame_rst_n = reset_n & ~chip_select_n & serial_mode_sel; // RL11
	assign mosi = data_in[`MOSI_PIN]; // RL10

	function automatic reg_addr_t order_addr(input logic [15:0] c, input logic sw);
		reg_addr_t a;
		a = '0;
		for (int k = 0; k < 13; k++) begin
			a[k] = sw ? c[13 - k] : c[`ADDR_LO_POS + k]; // RL5 RL7
		end
		return a;
	endfunction

	function automatic reg_data_t order_byte(input reg_data_t b, input logic sw);
		reg_data_t d;
		d = '0;
		for (int j = 0; j < 8; j++) begin
			d[j] = sw ? b[7 - j] : b[j]; // RL5 RL7
		end
		return d;
	endfunction

	always_comb begin
		next_ctrl = ctrl;
		next_ctrl[cnt[3:0]] = mosi;
		next_byte = rx_byte;
		next_byte[cnt[2:0]] = mosi;
	end

	always_ff @(posedge lclk or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			cnt <= 5'h00;
			phase <= ph_ctrl;
			ctrl <= 16'h0000;
			rx_byte <= 8'h00;
		end else begin
			cnt <= (cnt == `BYTE_END) ? `DATA_FIRST : 5'(cnt + 5'h01);
			case (phase)
				ph_ctrl: begin
					ctrl <= next_ctrl;
					if (cnt == `CTRL_LAST) begin
						phase <= ph_data;
					end
				end
				ph_data: begin
					rx_byte <= next_byte;
				end
				default: begin
					phase <= ph_ctrl;
				end
			endcase
		end
	end

	always_ff @(posedge lclk or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			lk_addr <= 13'h0000;
			lk_rw <= 1'b0;
			lk_burst <= 1'b0;
		end else if (phase == ph_ctrl && cnt == `CTRL_LAST) begin
			lk_addr <= order_addr(next_ctrl, swap);
			lk_rw <= next_ctrl[`RW_POS]; // RL6
			lk_burst <= next_ctrl[`BURST_POS]; // RL6
		end else if (phase == ph_data && cnt == `BYTE_END && lk_burst) begin
			lk_addr <= 13'(lk_addr + 13'h0001);
		end
	end

	// request toggle survives frame ends so the system side never misses one
	always_ff @(posedge lclk or negedge reset_n) begin
		if (!reset_n) begin
			xfer_tgl <= 1'b0;
			req_addr <= 13'h0000;
			req_wdata <= 8'h00;
			req_rw <= 1'b0;
		end else if (phase == ph_ctrl && cnt == `CTRL_LAST && next_ctrl[`RW_POS]) begin
			xfer_tgl <= ~xfer_tgl;
			req_addr <= order_addr(next_ctrl, swap);
			req_rw <= 1'b1;
		end else if (phase == ph_data && cnt == `BYTE_END && !lk_rw) begin
			xfer_tgl <= ~xfer_tgl;
			req_addr <= lk_addr;
			req_wdata <= order_byte(next_byte, swap); // RL1
			req_rw <= 1'b0;
		end else if (phase == ph_data && cnt == `BYTE_END && lk_burst) begin
			xfer_tgl <= ~xfer_tgl;
			req_addr <= 13'(lk_addr + 13'h0001);
			req_rw <= 1'b1;
		end
	end

	// read data is held by the system side; host must pause the clock for it
	always_ff @(negedge lclk or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			serial_data_out <= 1'b0;
		end else if (phase == ph_data && lk_rw) begin
			serial_data_out <= swap ? data_out[3'h7 - cnt[2:0]] : data_out[cnt[2:0]]; // RL7
		end else begin
			serial_data_out <= 1'b0;
		end
	end

	// ==========================================
	// request crossing and register side
	logic tgl_s1;
	logic tgl_s2;
	logic tgl_s3;
	logic ser_evt;
	logic par_rd_start;
	logic par_wr_end;
	logic rd_pend;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			tgl_s1 <= 1'b0;
			tgl_s2 <= 1'b0;
			tgl_s3 <= 1'b0;
		end else if (clk_en) begin
			tgl_s1 <= xfer_tgl;
			tgl_s2 <= tgl_s1;
			tgl_s3 <= tgl_s2;
		end
	end

	assign ser_evt = mode_s && (tgl_s2 ^ tgl_s3);
	assign par_rd_start = !mode_s && !cs_n_s && !rd_n_s && rd_n_d; // RL11
	assign par_wr_end = !mode_s && !cs_n_s && wr_n_s && !wr_n_d; // RL11

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			reg_rd <= 1'b0;
			reg_wr <= 1'b0;
			reg_addr <= 13'h0000;
			reg_wdata <= 8'h00;
			rd_pend <= 1'b0;
		end else if (clk_en) begin
			reg_rd <= (ser_evt && req_rw) || par_rd_start;
			reg_wr <= (ser_evt && !req_rw) || par_wr_end; // RL1
			rd_pend <= reg_rd;
			if (ser_evt) begin
				reg_addr <= req_addr;
				reg_wdata <= req_wdata;
			end else if (par_rd_start || par_wr_end) begin
				reg_addr <= addr_s;
				reg_wdata <= din_s; // RL1
			end
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			data_out <= 8'h00;
			data_oe <= 8'h00;
		end else if (clk_en) begin
			if (rd_pend) begin
				data_out <= reg_rdata; // RL1
			end
			if (cs_n_s) begin
				data_oe <= 8'h00; // RL2
			end else if (mode_s) begin
				data_oe <= 8'h01; // RL8 RL10
			end else begin
				data_oe <= rd_n_s ? 8'h00 : 8'hff; // RL1
			end
		end
	end

	// ==========================================
	// assertions
	localparam int gap_cyc = `READ_GAP_CYC;

	sequence deselect_seq;
		chip_select_n [*4];
	endsequence

	sequence par_read_seq;
		(!mode_s && !cs_n_s && !rd_n_s) [*3];
	endsequence

	a_oe_off_deselect: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL2
		clk_en [*4] ##0 deselect_seq |-> data_oe == 8'h00)
		else $error("data pins driven while deselected");

	a_read_drives_bus: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL1
		clk_en [*3] ##0 par_read_seq |-> data_oe == 8'hff)
		else $error("parallel read does not drive data pins");

	a_write_data_taken: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL1
		(clk_en && par_wr_end) |=> reg_wr && reg_wdata == $past(din_s))
		else $error("parallel write data not passed on");

	a_strobe_needs_cs: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL11
		(!mode_s && cs_n_s) |=> !reg_rd && !reg_wr)
		else $error("strobe honoured without chip select");

	a_strap_hold_par: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL14
		!mode_s |=> $stable({pol, pha, swap}))
		else $error("strap changed in parallel mode");

	a_strap_capture: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL3 RL4
		(clk_en && mode_s && cs_n_s) |=> pol == $past(din_s[`POL_PIN]) && pha == $past(din_s[`PHA_PIN]))
		else $error("polarity or phase strap not captured");

	a_serial_pin_roles: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL10
		(clk_en && mode_s && !cs_n_s) |=> data_oe == 8'h01)
		else $error("serial mode drives a pin other than data 0");

	a_serial_rw_flag: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL6
		(clk_en && ser_evt) |=> reg_rd == $past(req_rw) && reg_wr == !$past(req_rw))
		else $error("serial request direction lost");

	a_serial_read_gap: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL8
		(clk_en [*8] ##0 mode_s && $changed(xfer_tgl) && req_rw) |-> ##[1:gap_cyc] reg_rd)
		else $error("serial read not issued within the read gap");

	// frame reset would abort an attempt on a frame's last byte before the next link edge, so only system reset disables
	a_byte_order: assert property (@(posedge lclk) disable iff (!reset_n) // RL7
		(phase == ph_data && cnt == `BYTE_END && !lk_rw)
		|=> req_wdata[swap ? 0 : 7] == $past(mosi))
		else $error("serial data byte in wrong bit order");

endmodule

//--- hdl/host_port_pkg.sv
// types for the shared host data-pin port
package host_port_pkg;
	typedef enum logic [0:0] {
		ph_ctrl = 1'b0,
		ph_data = 1'b1
	} link_phase_e;
	typedef logic [12:0] reg_addr_t;
	typedef logic [7:0] reg_data_t;
endpackage

//--- verification/host_port_pins_tb.sv
// self-checking bench for the host data-pin port
module host_port_pins_tb
	import host_port_pkg::*;
();
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {reg_addr_t a; reg_data_t d;} row_s;
	row_s rows [4] = '{'{13'h0000, 8'hff}, '{13'h1fff, 8'h00}, '{13'h0a55, 8'ha5},
		'{13'h1234, 8'h5a}};
	logic clk_sys, reset_n, mode, p_cs, rd_n, wr_n, hen, pol, pha, swap;
	logic serial_data_out, reg_wr, reg_rd, sclk, mosi, m_cs;
	logic [1:0] sm;
	reg_addr_t addr_pin, reg_addr, sa;
	reg_data_t hd, data_out, data_oe, reg_wdata, q, sd;
	reg_data_t flt = 8'h5a;
	reg_data_t mem [0:15];
	int fail_count = 0;
	int num_checks = 0;
	int cyc = 0;
	int wr_cnt = 0;
	int n;
	wire logic cs_n = mode ? m_cs : p_cs;
	wire reg_data_t dv = mode ? {data_out[7:1], serial_data_out} : data_out;
	wire reg_data_t hm = mode ? 8'hfe : {8{hen}};
	wire reg_data_t hv = mode ? {pol, pha, swap, 2'h0, sclk, mosi, 1'b0} : hd;
	// an undriven line floats: show a changing pattern, never the last value
	wire reg_data_t pins = (data_oe & dv) | (~data_oe & hm & hv) | (~data_oe & ~hm & flt);
	host_port_pins DUT (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(1'b1),
		.serial_clk(pins[2] & mode), .serial_mode_sel(mode), .chip_select_n(cs_n),
		.read_n(rd_n), .write_n(wr_n), .addr_pin(addr_pin), .data_in(pins),
		.data_out(data_out), .data_oe(data_oe), .serial_data_out(serial_data_out),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(mem[reg_addr[3:0]]));
	host_serial_model host (.sclk(sclk), .mosi(mosi), .cs_n(m_cs), .miso(pins[0]), .pol(pol));
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	// ====
	// register side and watchdog
	always @(posedge clk_sys) begin
		flt <= ~flt;
		cyc <= cyc + 1;
		if (reg_wr === 1'b1) begin
			mem[reg_addr[3:0]] <= reg_wdata;
			wr_cnt <= wr_cnt + 1;
		end
		if (cyc == 20000) begin
			fail_count++;
			complete_run;
		end
	end
	// ====
	// tasks
	task tick;
		@(posedge clk_sys);
		#1;
	endtask
	task chk(input bit ok, input string m);
		num_checks++;
		if (!ok) begin
			fail_count++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask
	task complete_run;
		if (fail_count == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task pwrite(input reg_addr_t a, input reg_data_t d);
		p_cs = 1'b0;
		addr_pin = a;
		hd = d;
		hen = 1'b1;
		wr_n = 1'b0;
		repeat (3) tick;
		wr_n = 1'b1;
		repeat (3) tick;
		chk(reg_wr === 1'b1 && reg_addr === a && reg_wdata === d, "parallel write");
		tick;
		p_cs = 1'b1;
		hen = 1'b0;
	endtask
	task pread(input reg_addr_t a, input reg_data_t e);
		p_cs = 1'b0;
		addr_pin = a;
		rd_n = 1'b0;
		repeat (3) tick;
		chk(reg_rd === 1'b1 && reg_addr === a && data_oe === 8'hff, "read start");
		repeat (3) tick;
		chk(data_out === e && pins === e, "read data");
		rd_n = 1'b1;
		p_cs = 1'b1;
		repeat (4) tick;
		chk(data_oe === 8'h00, "bus not released");
	endtask
	// ====
	// main sequence
	initial begin
		{reset_n, mode, rd_n, wr_n, hen, pol, pha, swap} = 8'h30;
		p_cs = 1'b1;
		addr_pin = 13'h0000;
		hd = 8'h00;
		repeat (20) tick;
		reset_n = 1'b1;
		repeat (3) tick;
		chk(data_oe === 8'h00 && reg_wr === 1'b0 && serial_data_out === 1'b0, "reset");
		foreach (rows[i]) begin
			pwrite(rows[i].a, rows[i].d);
			pread(rows[i].a, rows[i].d);
		end
		n = wr_cnt;
		wr_n = 1'b0;
		rd_n = 1'b0;
		repeat (4) tick;
		wr_n = 1'b1;
		rd_n = 1'b1;
		repeat (6) tick;
		chk(wr_cnt == n && data_oe === 8'h00, "strobes taken while deselected");
		mode = 1'b1;
		for (int m = 0; m < 4; m++) begin
			sm = m[1:0];
			{pol, pha, swap} = {sm[1], sm[1], sm[0]};
			sa = {9'h1a5, 2'h0, sm};
			sd = {sm, 6'h2d};
			repeat (4) tick;
			n = wr_cnt;
			host.frame(1'b0, sa, sd, swap, q);
			tick;
			chk(wr_cnt == n + 1 && reg_addr === sa && mem[sa[3:0]] === sd, "serial wr");
			host.frame(1'b1, sa, 8'h00, swap, q);
			// chip select reaches the pin enables only after the synchroniser
			repeat (4) tick;
			chk(q === sd && data_oe === 8'h00, "serial rd");
		end
		complete_run;
	end
endmodule

//--- verification/host_serial_model.sv
// host-side serial master for the shared data pins
module host_serial_model
	import host_port_pkg::*;
(
	// link pins
	output logic sclk,
	output logic mosi,
	output logic cs_n,
	input wire logic miso,
	input wire logic pol
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		sclk = 1'b0;
		mosi = 1'b0;
		cs_n = 1'b1;
	end
	// ====
	// one frame, no burst; clock stands still outside it
	task frame(input logic rd, input reg_addr_t a, input reg_data_t d, input logic swap,
		output reg_data_t q);
		logic [23:0] b;
		b[0] = rd;
		for (int k = 1; k < 14; k++)
			b[k] = swap ? a[13 - k] : a[k - 1];
		b[15:14] = 2'h0;
		for (int j = 0; j < 8; j++)
			b[16 + j] = swap ? d[7 - j] : d[j];
		sclk = pol;
		#1.7;
		cs_n = 1'b0;
		for (int i = 0; i < 24; i++) begin
			#3;
			sclk = 1'b0;
			mosi = b[i];
			#3;
			if (i > 15)
				q[swap ? 23 - i : i - 16] = miso;
			sclk = 1'b1;
			// device needs time to fetch the register
			if (i == 15)
				#500;
		end
		#3;
		sclk = pol;
		#400;
		cs_n = 1'b1;
		mosi = ~mosi;
	endtask
endmodule
